//--- hdl/shaper_pkg.sv
// Purpose: shared constants and types for the output pulse shaper
// Assumes: core_clk is the synthesizer clock feeding every output path
// Notes: byte addresses, one 32-bit word per register
package shaper_pkg;
  localparam int NUM_PATHS = 2;
  // register map, address[5] selects the path
  localparam logic [4:0] OFS_DIV = 5'h00;
  localparam logic [4:0] OFS_DUTY = 5'h04;
  localparam logic [4:0] OFS_STEP = 5'h08;
  localparam logic [4:0] OFS_CTRL = 5'h0c;
  localparam logic [4:0] OFS_STAT = 5'h10;
  localparam int PATH_BIT = 5;
  // reset values
  localparam logic [31:0] RST_DIV = 32'h0000_0008;
  localparam logic [31:0] RST_DUTY = 32'h0000_0000;
  localparam logic [31:0] RST_STEP = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  // control field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_SE = 1;
  localparam int CTRL_INV = 2;
  localparam int CTRL_SWING = 4;
  localparam int CTRL_IMP = 6;
  localparam int CTRL_CM = 8;
  localparam int CTRL_SUP = 12;
  localparam logic [31:0] CTRL_MASK = 32'h0000_7ff7;
  // status field positions
  localparam int STAT_PEND = 0;
  localparam int STAT_LEVEL = 1;
  // shortest high or low portion after a shortening step, in cycles
  localparam logic [33:0] MIN_PHASE = 34'h2;

  typedef enum logic [1:0] {PH_IDLE, PH_HIGH, PH_LOW} phase_t;

  typedef struct packed {
    logic [31:0] div;
    logic [31:0] duty;
    logic en;
  } shape_cfg_t;

  typedef struct packed {
    logic se_mode;
    logic invert;
    logic [1:0] swing;
    logic [1:0] imped;
    logic [2:0] cm;
    logic [2:0] supply;
  } buf_cfg_t;

  typedef struct packed {
    logic true_output_pin;
    logic complement_output_pin;
    logic diff_mode;
    logic [1:0] swing_select;
    logic [1:0] impedance_select;
    logic [2:0] common_mode_select;
    logic [2:0] supply_level_select;
  } buf_pins_t;
endpackage

//--- hdl/period_shaper.sv
// Purpose: divides the synthesizer clock and shapes each output period
// Assumes: software keeps duty below div and avoids steps for div 1..4
// Notes: div of 1 still yields a two-cycle period, the fastest possible
`timescale 1ns/1ps
module period_shaper
  import shaper_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input shape_cfg_t cfg,
  input wire logic step_req,
  input wire logic [31:0] step_val,
  output logic level,
  output logic step_pending
);
  phase_t state_q;
  logic [33:0] cnt_q;
  logic [33:0] lo_q;
  logic [31:0] step_q;
  logic pend_q;

  // clamps a shortened portion, only when a step is being applied
  function automatic logic [33:0] fit(input logic signed [34:0] v, input logic adj);
    if (adj && (v < $signed({1'b0, MIN_PHASE}))) begin
      fit = MIN_PHASE;
    end else begin
      fit = v[33:0];
    end
  endfunction

  wire equal = (cfg.duty == 32'h0); // zero width means 50/50
  wire [32:0] div_p1 = {1'b0, cfg.div} + 33'h1;
  // nominal portions: 50/50 split or programmed pulse
  wire [33:0] base_hi = equal ? {1'b0, div_p1[32:0]} >> 1 : {2'b00, cfg.duty};
  wire [33:0] base_lo = {2'b00, cfg.div} - base_hi;
  // signed step, split evenly or put all on the low portion
  wire signed [34:0] adj = pend_q ? {{3{step_q[31]}}, step_q} : 35'sh0;
  wire signed [34:0] adj_hi = equal ? (adj >>> 1) : 35'sh0;
  wire signed [34:0] adj_lo = adj - adj_hi;
  // lengthen or shorten one period, never below 2+2 cycles
  wire [33:0] hi_len = fit($signed({1'b0, base_hi}) + adj_hi, pend_q);
  wire [33:0] lo_len = fit($signed({1'b0, base_lo}) + adj_lo, pend_q);
  wire last = (cnt_q <= 34'h1);
  wire start = cfg.en & ((state_q == PH_IDLE) | ((state_q == PH_LOW) & last));

  // phase counter; high portion always first so pulses go high
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= PH_IDLE;
      cnt_q <= 34'h0;
      lo_q <= 34'h0;
    end else begin
      case (state_q)
        PH_IDLE, PH_LOW: begin
          if (!cfg.en) begin
            state_q <= PH_IDLE;
          end else if (start) begin
            state_q <= PH_HIGH; // edges moved per output in whole cycles
            cnt_q <= hi_len;
            lo_q <= lo_len;
          end else begin
            cnt_q <= cnt_q - 34'h1;
          end
        end
        PH_HIGH: begin
          if (!cfg.en) begin
            state_q <= PH_IDLE;
          end else if (last) begin
            state_q <= PH_LOW;
            cnt_q <= lo_q;
          end else begin
            cnt_q <= cnt_q - 34'h1;
          end
        end
        default: state_q <= PH_IDLE;
      endcase
    end
  end

  // one write, one step at the next period start; new write beats clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      step_q <= 32'h0;
      pend_q <= 1'b0;
    end else if (step_req) begin
      step_q <= step_val; // requests accepted without limit
      pend_q <= 1'b1;
    end else if (start & pend_q) begin
      pend_q <= 1'b0; // back to normal periods afterwards
    end
  end

  assign level = (state_q == PH_HIGH);
  assign step_pending = pend_q;
endmodule // period_shaper

//--- hdl/output_buffer.sv
// Purpose: drives one output buffer from a shaped level
// Assumes: level is decoded from the state_q flops on core_clk
// Notes: analog levels are only passed on as select codes
`timescale 1ns/1ps
module output_buffer
  import shaper_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic level,
  input buf_cfg_t cfg,
  output buf_pins_t pins
);
  // complement follows or inverts in single-ended, inverts in differential
  wire comp_se = cfg.invert ? ~level : level;
  wire comp_d = cfg.se_mode ? comp_se : ~level;
  // swing and common mode only mean something when differential
  wire [1:0] swing_d = cfg.se_mode ? 2'h0 : cfg.swing;
  wire [2:0] cm_d = cfg.se_mode ? 3'h0 : cfg.cm;
  // impedance choice only in single-ended mode
  wire [1:0] imp_d = cfg.se_mode ? cfg.imped : 2'h0;

  // registered pins keep the outputs glitch free
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pins <= '0;
    end else begin
      pins.true_output_pin <= level;
      pins.complement_output_pin <= comp_d;
      pins.diff_mode <= ~cfg.se_mode;
      pins.swing_select <= swing_d;
      pins.impedance_select <= imp_d;
      pins.common_mode_select <= cm_d;
      pins.supply_level_select <= cfg.supply;
    end
  end
endmodule // output_buffer

//--- hdl/output_pulse_shaper_phase_adjust.sv
// Purpose: dual output stage with pulse shaping and coarse phase steps
// Assumes: Avalon-MM master holds each request until waitrequest is low
// Notes: every access answers after one wait cycle; unmapped reads give 0
`timescale 1ns/1ps
module output_pulse_shaper_phase_adjust
  import shaper_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output buf_pins_t [NUM_PATHS-1:0] out_pins
);
  logic [31:0] div_q [NUM_PATHS];
  logic [31:0] duty_q [NUM_PATHS];
  logic [31:0] step_q [NUM_PATHS];
  logic [31:0] ctrl_q [NUM_PATHS];
  logic [NUM_PATHS-1:0] step_req_q;
  logic [NUM_PATHS-1:0] level_w;
  logic [NUM_PATHS-1:0] pend_w;
  logic wait_q;
  logic [31:0] rdata_q;

  // byte-lane merge of a write into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    merge = r;
  endfunction

  // address decode; upper bits and misaligned addresses are unmapped
  wire req = avs_read | avs_write;
  wire path = avs_address[PATH_BIT];
  wire [4:0] ofs = avs_address[4:0];
  wire in_range = (avs_address[7:6] == 2'h0);
  wire hit_div = in_range & (ofs == OFS_DIV);
  wire hit_duty = in_range & (ofs == OFS_DUTY);
  wire hit_step = in_range & (ofs == OFS_STEP);
  wire hit_ctrl = in_range & (ofs == OFS_CTRL);
  wire hit_stat = in_range & (ofs == OFS_STAT);
  // write takes effect at the edge where the master sees waitrequest low
  wire wr_take = avs_write & ~wait_q;

  // status word shows live state of the selected path
  wire [31:0] stat_w = {30'h0, level_w[path], pend_w[path]};

  // read selection
  wire [31:0] rd_word = hit_div ? div_q[path] :
                        hit_duty ? duty_q[path] :
                        hit_step ? step_q[path] :
                        hit_ctrl ? ctrl_q[path] :
                        hit_stat ? stat_w : 32'h0;

  // one wait cycle per access, then release for one cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else if (req & wait_q) begin
      wait_q <= 1'b0;
      rdata_q <= avs_read ? rd_word : 32'h0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // two identical paths fed from the same synthesizer clock
  for (genvar p = 0; p < NUM_PATHS; p++) begin : g_path
    wire sel = (path == 1'(p));
    wire we_div = wr_take & sel & hit_div;
    wire we_duty = wr_take & sel & hit_duty;
    wire we_step = wr_take & sel & hit_step;
    wire we_ctrl = wr_take & sel & hit_ctrl;
    wire [31:0] ctrl_new = merge(ctrl_q[p], avs_writedata, avs_byteenable) & CTRL_MASK;
    shape_cfg_t scfg;
    buf_cfg_t bcfg;

    // configuration registers of this path
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        div_q[p] <= RST_DIV;
        duty_q[p] <= RST_DUTY;
        step_q[p] <= RST_STEP;
        ctrl_q[p] <= RST_CTRL;
        step_req_q[p] <= 1'b0;
      end else begin
        if (we_div) begin
          div_q[p] <= merge(div_q[p], avs_writedata, avs_byteenable);
        end
        if (we_duty) begin
          duty_q[p] <= merge(duty_q[p], avs_writedata, avs_byteenable);
        end
        if (we_step) begin
          step_q[p] <= merge(step_q[p], avs_writedata, avs_byteenable);
        end
        if (we_ctrl) begin
          ctrl_q[p] <= ctrl_new;
        end
        step_req_q[p] <= we_step; // each write is one request
      end
    end

    // unpack control into the shaper and buffer carriers
    assign scfg.div = div_q[p];
    assign scfg.duty = duty_q[p];
    assign scfg.en = ctrl_q[p][CTRL_EN];
    assign bcfg.se_mode = ctrl_q[p][CTRL_SE];
    assign bcfg.invert = ctrl_q[p][CTRL_INV];
    assign bcfg.swing = ctrl_q[p][CTRL_SWING +: 2];
    assign bcfg.imped = ctrl_q[p][CTRL_IMP +: 2];
    assign bcfg.cm = ctrl_q[p][CTRL_CM +: 3];
    assign bcfg.supply = ctrl_q[p][CTRL_SUP +: 3];

    period_shaper u_shaper (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .cfg(scfg),
      .step_req(step_req_q[p]),
      .step_val(step_q[p]),
      .level(level_w[p]),
      .step_pending(pend_w[p])
    );

    output_buffer u_buffer (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .level(level_w[p]),
      .cfg(bcfg),
      .pins(out_pins[p])
    );
  end
endmodule // output_pulse_shaper_phase_adjust

//--- verif/clock_receiver_model.sv
// Purpose: downstream receiver that times each output clock period
// Assumes: pin is sampled on core_clk
// Notes: a period closes at the rise that starts the next one
`timescale 1ns/1ps
module clock_receiver_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic pin,
  output logic [31:0] hi_len,
  output logic [31:0] lo_len,
  output logic [31:0] periods
);
  logic [31:0] run_q;
  logic last_q;
  // run lengths latched at each pin change
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {run_q, last_q, hi_len, lo_len, periods} <= '0;
    end else if (pin != last_q) begin
      run_q <= 32'h1;
      last_q <= pin;
      if (last_q) hi_len <= run_q;
      else begin
        lo_len <= run_q;
        periods <= periods + 32'h1;
      end
    end else begin
      run_q <= run_q + 32'h1;
    end
  end
endmodule // clock_receiver_model

//--- verif/output_pulse_shaper_phase_adjust_asserts.sv
// Purpose: bus and pin relations of the output stage
// Assumes: only top module ports are visible
// Notes: select codes are checked, not analog levels
`timescale 1ns/1ps
module output_pulse_shaper_phase_adjust_asserts
  import shaper_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input buf_pins_t [NUM_PATHS-1:0] out_pins
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // shorthands
  wire logic rq = avs_read | avs_write;
  wire buf_pins_t a = out_pins[0];
  wire buf_pins_t b = out_pins[1];
  chk_wait_answer: assert property (rq && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_wait_idle: assert property (!rq && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  chk_rdata_hold: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data moved between answers");
  chk_diff_compl: assert property (a.diff_mode |->
    a.complement_output_pin != a.true_output_pin)
    else $error("differential pair not complementary");
  chk_path_two: assert property (b.diff_mode |->
    b.complement_output_pin != b.true_output_pin)
    else $error("second buffer pair not complementary");
  // the xor of the copies only moves when control is rewritten
  chk_se_copy: assert property (
    !a.diff_mode && !$past(avs_write) && !$past(avs_write, 2) |->
    $stable(a.true_output_pin ^ a.complement_output_pin))
    else $error("single-ended copies drift apart");
  chk_swing_se: assert property (!a.diff_mode |-> a.swing_select == 2'h0)
    else $error("swing code in single-ended mode");
  chk_imp_diff: assert property (a.diff_mode |-> a.impedance_select == 2'h0)
    else $error("impedance code in differential mode");
  cover property (avs_read && !avs_waitrequest);
  cover property (!a.diff_mode && a.complement_output_pin != a.true_output_pin);
  cover property ($rose(a.true_output_pin));
endmodule // output_pulse_shaper_phase_adjust_asserts
bind output_pulse_shaper_phase_adjust output_pulse_shaper_phase_adjust_asserts u_chk (
  .core_clk, .arst_n, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .out_pins);

//--- verif/output_pulse_shaper_phase_adjust_tb_top.sv
// Purpose: register and period tests of the dual output stage
// Assumes: software keeps duty below div and steps only for div above 4
// Notes: periods are timed by the receiver models
`timescale 1ns/1ps
module output_pulse_shaper_phase_adjust_tb_top;
  import shaper_pkg::*;
  logic core_clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d, h, l;
  logic [3:0] avs_byteenable;
  buf_pins_t [NUM_PATHS-1:0] out_pins;
  logic [31:0] hi_len[2], lo_len[2], periods[2];
  logic [4:0] ofs[4] = '{OFS_DIV, OFS_DUTY, OFS_STEP, OFS_CTRL};
  logic [31:0] rv[4] = '{RST_DIV, RST_DUTY, RST_STEP, RST_CTRL};
  int err_count, n_tests, cyc;
  output_pulse_shaper_phase_adjust DUT (.core_clk, .arst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .out_pins);
  for (genvar p = 0; p < 2; p++) begin : g_rx
    clock_receiver_model rx (.core_clk, .arst_n, .pin(out_pins[p].true_output_pin),
      .hi_len(hi_len[p]), .lo_len(lo_len[p]), .periods(periods[p]));
  end
  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end
  // hang guard, far above the few hundred cycles needed
  initial cyc = 0;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus cycle; request held until waitrequest is seen low at a rising edge
  task automatic access(input int wr, input int p, input logic [4:0] o,
                        input logic [31:0] wd);
    @(posedge core_clk);
    avs_address <= {3'(p), o};
    avs_writedata <= wd;
    avs_read <= (wr == 0);
    avs_write <= (wr != 0);
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic get_period(input int p);
    logic [31:0] n;
    n = periods[p];
    wait (periods[p] != n);
    @(negedge core_clk);
    h = hi_len[p];
    l = lo_len[p];
  endtask
  task automatic settle();
    repeat (3) get_period(0);
  endtask
  // step lands on the period after the one in progress, then periods return
  task automatic step_chk(input logic [31:0] s, input logic [31:0] eh, input logic [31:0] el,
                          input logic [31:0] nh, input logic [31:0] nl);
    get_period(0);
    access(1, 0, OFS_STEP, s);
    get_period(0);
    get_period(0);
    check(h, eh);
    check(l, el);
    get_period(0);
    check(h, nh);
    check(l, nl);
  endtask
  task automatic pins_chk(input logic [31:0] c, input logic [31:0] x, input logic [31:0] k);
    access(1, 0, OFS_CTRL, c);
    repeat (2) @(negedge core_clk);
    check(32'(out_pins[0].true_output_pin ^ out_pins[0].complement_output_pin), x);
    check(32'(out_pins[0].diff_mode), 32'(!c[CTRL_SE]));
    check(32'(c[CTRL_SE] ? out_pins[0].impedance_select : out_pins[0].swing_select), k);
    check(32'(out_pins[0].supply_level_select), 32'(c[14:12]));
    check(32'(out_pins[0].common_mode_select), c[CTRL_SE] ? 32'h0 : 32'(c[CTRL_CM +: 3]));
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    {arst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) for (int p = 0; p < 2; p++) begin
      access(0, p, ofs[i], 0);
      check(d, rv[i]);
    end
    access(1, 2, OFS_DIV, 32'h5);
    access(0, 0, OFS_DIV, 0);
    check(d, RST_DIV);
    access(1, 1, OFS_CTRL, '1);
    access(0, 1, OFS_CTRL, 0);
    check(d, CTRL_MASK);
    $display("test registers done");
    access(1, 0, OFS_DIV, 9);
    access(1, 0, OFS_CTRL, 1);
    access(1, 1, OFS_DIV, 6);
    access(1, 1, OFS_CTRL, 1);
    settle();
    check(h, 5);
    check(l, 4);
    get_period(1);
    check(h + l, 6);
    access(1, 0, OFS_DIV, 10);
    access(1, 0, OFS_DUTY, 3);
    settle();
    check(h, 3);
    check(l, 10 - 3);
    step_chk(5, 3, 7 + 5, 3, 7);
    step_chk(32'hffff_fffc, 3, 7 - 4, 3, 7);
    step_chk(32'hffff_fff6, 3, 2, 3, 7);
    $display("test pulse done");
    access(1, 0, OFS_DIV, 8);
    access(1, 0, OFS_DUTY, 0);
    settle();
    step_chk(3, 4 + 1, 4 + 2, 4, 4);
    step_chk(32'hffff_fffa, 2, 2, 4, 4);
    repeat (3) step_chk(2, 5, 5, 4, 4);
    $display("test steps done");
    pins_chk(32'h0000_3307, 1, 0);
    pins_chk(32'h0000_2003, 0, 0);
    for (int k = 0; k < 4; k++) begin
      pins_chk(32'h1301 | (k << CTRL_SWING), 1, k);
      pins_chk(32'h1007 | (k << CTRL_IMP), 1, k);
    end
    $display("test buffers done");
    results();
  end
endmodule // output_pulse_shaper_phase_adjust_tb_top
